// >>> rtl/vicu_arbiter.sv
// per-target winner search: highest priority above threshold, lowest index on ties
`include "vicu_cfg.svh"
module vicu_arbiter (
  input  wire logic [55:0]              req_i,
  input  wire logic [55:0]              tgt_sel_i,
  input  wire logic                     tgt_i,
  input  wire logic [223:0]             prio_i,
  input  wire vicu_pkg::vicu_prio_t     thr_i,
  output logic                          hit_o,
  output vicu_pkg::vicu_idx_t           idx_o,
  output vicu_pkg::vicu_prio_t          prio_o
);
  // strict compare against threshold; priority 0 can never exceed anything
  always_comb begin
    hit_o  = 1'b0;
    idx_o  = vicu_pkg::vicu_idx_t'(`VICU_NO_WIN);
    prio_o = 4'h0;
    for (int i = 0; i < `VICU_NUM_REQ; i++) begin
      if (req_i[i] && (tgt_sel_i[i] == tgt_i) && (prio_i[i*4 +: 4] > thr_i) &&
          (prio_i[i*4 +: 4] > prio_o)) begin  // strict > keeps lowest index on ties
        hit_o  = 1'b1;
        idx_o  = vicu_pkg::vicu_idx_t'(i);
        prio_o = prio_i[i*4 +: 4];
      end
    end
  end
endmodule : vicu_arbiter

// >>> rtl/vicu_cfg.svh
// register offsets, field positions and reset values of the vectored interrupt unit
`ifndef VICU_CFG_SVH
`define VICU_CFG_SVH
`define VICU_NUM_REQ      56
`define VICU_PRIO_W       4
`define VICU_ADDR_W       10
// per-input config words at 0x000 + 4*n: [3:0] priority, [8] target, [16] polarity, [24] soft request
`define VICU_CFG_BASE     10'h000
`define VICU_CFG_LAST     10'h0dc
`define VICU_CFG_PRIO_LSB 0
`define VICU_CFG_TGT_BIT  8
`define VICU_CFG_POL_BIT  16
`define VICU_CFG_SWR_BIT  24
`define VICU_RAW_LO       10'h100
`define VICU_RAW_HI       10'h104
`define VICU_THR_FAST     10'h108
`define VICU_THR_STD      10'h10c
`define VICU_VEC_FAST     10'h110
`define VICU_VEC_STD      10'h114
`define VICU_IRQ_STAT     10'h118
`define VICU_IRQ_MASK     10'h11c
`define VICU_THR_RESET    4'h0
`define VICU_MASK_RESET   2'h0
`define VICU_NO_WIN       6'h3f
`endif

// >>> rtl/vicu_pkg.sv
// types shared by the vectored interrupt unit
package vicu_pkg;
  typedef logic [3:0] vicu_prio_t;
  typedef logic [5:0] vicu_idx_t;
  typedef enum logic [1:0] {
    VICU_BUS_IDLE = 2'b00,
    VICU_BUS_ACK  = 2'b01
  } vicu_bus_state_t;
endpackage : vicu_pkg

// >>> rtl/vicu_top.sv
// vectored interrupt unit: 56 level requests to fast and standard interrupt lines
// Contract
// - there are 56 level-sensitive request inputs, each with a software-chosen active level.
// - each input has a software request bit that asserts the request whatever the line level and its polarity.
// - software reads each request after polarity handling and before priority masking.
// - each input has a four-bit priority field with fifteen usable levels.
// - software routes each input to either the fast or the standard interrupt line.
// - target value 0 means the fast line and value 1 the standard line.
// - masking compares each request priority with the threshold of its own target.
// - a priority of 0 masks the request on both targets whatever the threshold.
// - priority 1 is lowest and 15 highest, larger wins.
// - each target has a readable vector naming its winning request.
// - nesting works by software raising a target threshold inside a handler.
// - all logic runs on the single gated branch clock and there are no pins.
// - the unit is reset by the system warm reset.
`include "vicu_cfg.svh"
module vicu_top (
  input  wire logic        CLOCK_I,
  input  wire logic        RESET_N_I,
  input  wire logic [55:0] IRQ_REQ_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [9:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             FAST_INTERRUPT_LINE_O,
  output logic             STD_INTERRUPT_LINE_O,
  output logic             EVENT_IRQ_O
);
  logic [223:0]        prio_q;
  logic [55:0]         tgt_q;
  logic [55:0]         pol_q;
  logic [55:0]         swr_q;
  vicu_pkg::vicu_prio_t thr_fast_q;
  vicu_pkg::vicu_prio_t thr_std_q;
  logic [1:0]          stat_q;
  logic [1:0]          mask_q;
  logic [1:0]          line_q;
  logic [31:0]         dat_q;
  logic [55:0]         raw;
  logic                take;
  logic                wr;
  logic                hit_f;
  logic                hit_s;
  vicu_pkg::vicu_idx_t idx_f;
  vicu_pkg::vicu_idx_t idx_s;
  vicu_pkg::vicu_prio_t win_f;
  vicu_pkg::vicu_prio_t win_s;
  logic [1:0]          line_d;
  logic [5:0]          cfg_n;

  // word index of a per-input config register
  function automatic logic [5:0] cfg_index(input logic [9:0] a);
    cfg_index = a[7:2];
  endfunction : cfg_index

  // is this address inside the per-input config block
  function automatic logic is_cfg(input logic [9:0] a);
    is_cfg = (a >= `VICU_CFG_BASE) && (a <= `VICU_CFG_LAST) && (a[1:0] == 2'h0);
  endfunction : is_cfg

  vicu_wb_slave u_wb (
    .CLOCK_I   (CLOCK_I),
    .RESET_N_I (RESET_N_I),
    .cyc_i     (WB_CYC_I),
    .stb_i     (WB_STB_I),
    .ack_o     (WB_ACK_O),
    .take_o    (take)
  );

  assign wr    = take && WB_WE_I;
  assign cfg_n = cfg_index(WB_ADR_I);

  // polarity flip then software request or-ed in, before any masking
  assign raw = (IRQ_REQ_I ^ pol_q) | swr_q;

  // one search per target; target bit 0 is fast, 1 is standard
  vicu_arbiter u_arb_fast (
    .req_i     (raw),
    .tgt_sel_i (tgt_q),
    .tgt_i     (1'b0),
    .prio_i    (prio_q),
    .thr_i     (thr_fast_q),
    .hit_o     (hit_f),
    .idx_o     (idx_f),
    .prio_o    (win_f)
  );
  vicu_arbiter u_arb_std (
    .req_i     (raw),
    .tgt_sel_i (tgt_q),
    .tgt_i     (1'b1),
    .prio_i    (prio_q),
    .thr_i     (thr_std_q),
    .hit_o     (hit_s),
    .idx_o     (idx_s),
    .prio_o    (win_s)
  );

  // per-input configuration; byte 0 priority, byte 1 target, byte 2 polarity, byte 3 soft request
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin  // warm reset clears all
      prio_q <= '0;
      tgt_q  <= '0;
      pol_q  <= '0;
      swr_q  <= '0;
    end else if (wr && is_cfg(WB_ADR_I)) begin
      if (WB_SEL_I[0]) prio_q[cfg_n*4 +: 4] <= WB_DAT_I[3:0];
      if (WB_SEL_I[1]) tgt_q[cfg_n]         <= WB_DAT_I[`VICU_CFG_TGT_BIT];
      if (WB_SEL_I[2]) pol_q[cfg_n]         <= WB_DAT_I[`VICU_CFG_POL_BIT];
      if (WB_SEL_I[3]) swr_q[cfg_n]         <= WB_DAT_I[`VICU_CFG_SWR_BIT];
    end
  end

  // thresholds, writable any time so a handler can raise them for nesting
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      thr_fast_q <= `VICU_THR_RESET;
      thr_std_q  <= `VICU_THR_RESET;
    end else if (wr && WB_SEL_I[0]) begin
      if (WB_ADR_I == `VICU_THR_FAST) thr_fast_q <= WB_DAT_I[3:0];
      else if (WB_ADR_I == `VICU_THR_STD) thr_std_q <= WB_DAT_I[3:0];
    end
  end

  // target lines follow the level, registered for clean outputs
  assign line_d = {hit_s, hit_f};
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) line_q <= 2'h0;
    else            line_q <= line_d;
  end
  assign FAST_INTERRUPT_LINE_O = line_q[0];
  assign STD_INTERRUPT_LINE_O  = line_q[1];

  // event status: rising edge of a target line sets, write one clears; set wins
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      stat_q <= 2'h0;
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (line_d[t] && !line_q[t]) stat_q[t] <= 1'b1;
        else if (wr && WB_SEL_I[0] && WB_ADR_I == `VICU_IRQ_STAT && WB_DAT_I[t]) stat_q[t] <= 1'b0;
      end
    end
  end

  // event mask gates the summary output
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) mask_q <= `VICU_MASK_RESET;
    else if (wr && WB_SEL_I[0] && WB_ADR_I == `VICU_IRQ_MASK) mask_q <= WB_DAT_I[1:0];
  end
  assign EVENT_IRQ_O = |(stat_q & mask_q);

  // read data registered at request; unmapped reads zero
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      dat_q <= 32'h0;
    end else if (WB_CYC_I && WB_STB_I && !WB_ACK_O) begin
      dat_q <= 32'h0;
      if (is_cfg(WB_ADR_I)) begin
        dat_q[3:0]                <= prio_q[cfg_n*4 +: 4];
        dat_q[`VICU_CFG_TGT_BIT]  <= tgt_q[cfg_n];
        dat_q[`VICU_CFG_POL_BIT]  <= pol_q[cfg_n];
        dat_q[`VICU_CFG_SWR_BIT]  <= swr_q[cfg_n];
      end else if (WB_ADR_I == `VICU_RAW_LO) dat_q <= raw[31:0];
      else if (WB_ADR_I == `VICU_RAW_HI) dat_q <= {8'h0, raw[55:32]};
      else if (WB_ADR_I == `VICU_THR_FAST) dat_q <= {28'h0, thr_fast_q};
      else if (WB_ADR_I == `VICU_THR_STD) dat_q <= {28'h0, thr_std_q};
      else if (WB_ADR_I == `VICU_VEC_FAST) dat_q <= {15'h0, hit_f, 4'h0, win_f, 2'h0, idx_f};
      else if (WB_ADR_I == `VICU_VEC_STD) dat_q <= {15'h0, hit_s, 4'h0, win_s, 2'h0, idx_s};
      else if (WB_ADR_I == `VICU_IRQ_STAT) dat_q <= {30'h0, stat_q};
      else if (WB_ADR_I == `VICU_IRQ_MASK) dat_q <= {30'h0, mask_q};
    end
  end
  assign WB_DAT_O = dat_q;

  // checks: one clock, synchronous reset, no pins beyond bus and lines
  logic [1:0]  rise;
  logic [3:0]  wdat_nib;
  logic [31:0] raw_lo;
  logic        beat_f;
  logic        beat_s;
  assign rise     = line_d & ~line_q;
  assign wdat_nib = WB_DAT_I[3:0];
  assign raw_lo   = raw[31:0];

  // independent rescan for a qualifying request that beats the reported winner
  function automatic logic outranks(input logic [55:0] req, input logic [55:0] sel, input logic [223:0] pr,
                                    input logic t, input logic [3:0] thr, input logic [3:0] win,
                                    input logic [5:0] idx);
    outranks = 1'b0;
    for (int i = 0; i < `VICU_NUM_REQ; i++) begin
      if (req[i] && (sel[i] == t) && (pr[i*4 +: 4] > thr) &&
          ((pr[i*4 +: 4] > win) || ((pr[i*4 +: 4] == win) && (i < int'(idx))))) begin
        outranks = 1'b1;
      end
    end
  endfunction : outranks

  // an idle target reports no winner, so any qualifying request counts as missed
  always_comb begin
    beat_f = outranks(raw, tgt_q, prio_q, 1'b0, thr_fast_q, win_f, idx_f);
    beat_s = outranks(raw, tgt_q, prio_q, 1'b1, thr_std_q, win_s, idx_s);
  end

  // bus steps shared by the handshake and register checks
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ack_pulse;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  sequence s_thr_fast_wr;
    WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == `VICU_THR_FAST);
  endsequence
  sequence s_thr_std_wr;
    WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == `VICU_THR_STD);
  endsequence
  sequence s_rd_raw_lo;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && (WB_ADR_I == `VICU_RAW_LO);
  endsequence
  sequence s_rd_vec_f;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && (WB_ADR_I == `VICU_VEC_FAST);
  endsequence

  // winners: never priority 0, always above threshold, never outranked
  property p_zero_prio_never;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      hit_f |-> (win_f != 4'h0);
  endproperty
  a_zero_prio_never: assert property (p_zero_prio_never) else $error("zero priority won fast target");

  property p_zero_prio_std;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      hit_s |-> (win_s != 4'h0);
  endproperty
  a_zero_prio_std: assert property (p_zero_prio_std) else $error("zero priority won std target");

  property p_above_thr_f;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      hit_f |-> (win_f > thr_fast_q) && raw[idx_f] && !tgt_q[idx_f];
  endproperty
  a_above_thr_f: assert property (p_above_thr_f) else $error("fast winner not qualifying");

  property p_above_thr_s;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      hit_s |-> (win_s > thr_std_q) && raw[idx_s] && tgt_q[idx_s];
  endproperty
  a_above_thr_s: assert property (p_above_thr_s) else $error("standard winner not qualifying");

  property p_highest;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      !beat_f;
  endproperty
  a_highest: assert property (p_highest) else $error("fast winner below a candidate");

  property p_top_s;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      !beat_s;
  endproperty
  a_top_s: assert property (p_top_s) else $error("standard winner below a candidate");

  property p_tgt_split;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      !(hit_f && hit_s && (idx_f == idx_s));
  endproperty
  a_tgt_split: assert property (p_tgt_split) else $error("one input won both targets");

  property p_vec_none_f;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      !hit_f |-> (idx_f == `VICU_NO_WIN) && (win_f == 4'h0);
  endproperty
  a_vec_none_f: assert property (p_vec_none_f) else $error("idle fast vector not empty");

  // lines are the winners' flags one cycle late, and status catches each rise
  property p_fast_follow;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      hit_f |=> FAST_INTERRUPT_LINE_O;
  endproperty
  a_fast_follow: assert property (p_fast_follow) else $error("fast line missing");

  property p_fast_drop;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      !hit_f |=> !FAST_INTERRUPT_LINE_O;
  endproperty
  a_fast_drop: assert property (p_fast_drop) else $error("fast line stuck");

  property p_std_follow;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      hit_s |=> STD_INTERRUPT_LINE_O;
  endproperty
  a_std_follow: assert property (p_std_follow) else $error("standard line missing");

  property p_std_drop;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      !hit_s |=> !STD_INTERRUPT_LINE_O;
  endproperty
  a_std_drop: assert property (p_std_drop) else $error("standard line stuck");

  property p_stat_set;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      (|rise) |=> ((stat_q & $past(rise)) == $past(rise));
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("line rise not latched");

  // request front end and register view
  property p_raw_polarity;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      !swr_q[0] |-> (raw[0] == (IRQ_REQ_I[0] ^ pol_q[0]));
  endproperty
  a_raw_polarity: assert property (p_raw_polarity) else $error("polarity wrong on input 0");

  property p_soft_req;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      swr_q[0] |-> raw[0];
  endproperty
  a_soft_req: assert property (p_soft_req) else $error("soft request ignored");

  property p_raw_read;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      s_rd_raw_lo |=> WB_ACK_O && (WB_DAT_O == $past(raw_lo));
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("raw request read wrong");

  property p_vec_read;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      s_rd_vec_f |=> (WB_DAT_O[5:0] == $past(idx_f)) && (WB_DAT_O[16] == $past(hit_f));
  endproperty
  a_vec_read: assert property (p_vec_read) else $error("fast vector read wrong");

  property p_thr_fast_wr;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      s_thr_fast_wr |=> (thr_fast_q == $past(wdat_nib));
  endproperty
  a_thr_fast_wr: assert property (p_thr_fast_wr) else $error("fast threshold write lost");

  property p_thr_std_wr;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      s_thr_std_wr |=> (thr_std_q == $past(wdat_nib));
  endproperty
  a_thr_std_wr: assert property (p_thr_std_wr) else $error("standard threshold write lost");

  property p_ack_one;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
      s_req |=> s_ack_pulse;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("bus ack timing wrong");

  // warm reset quiets every output, so this one has no disable
  property p_reset_quiet;
    @(posedge CLOCK_I)
      !RESET_N_I |=> !FAST_INTERRUPT_LINE_O && !STD_INTERRUPT_LINE_O && !EVENT_IRQ_O && !WB_ACK_O;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");
endmodule : vicu_top

// >>> rtl/vicu_wb_slave.sv
// classic wishbone slave handshake: one ack per request, dropped the cycle after
module vicu_wb_slave (
  input  wire logic CLOCK_I,
  input  wire logic RESET_N_I,
  input  wire logic cyc_i,
  input  wire logic stb_i,
  output logic      ack_o,
  output logic      take_o
);
  vicu_pkg::vicu_bus_state_t state_q;
  // leave idle on a request, ack and take the next cycle, then back to idle so ack lasts one cycle
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      state_q <= vicu_pkg::VICU_BUS_IDLE;
    end else begin
      case (state_q)
        vicu_pkg::VICU_BUS_IDLE: if (cyc_i && stb_i) state_q <= vicu_pkg::VICU_BUS_ACK;
        vicu_pkg::VICU_BUS_ACK:  state_q <= vicu_pkg::VICU_BUS_IDLE;
        default:                 state_q <= vicu_pkg::VICU_BUS_IDLE;
      endcase
    end
  end
  assign ack_o  = (state_q == vicu_pkg::VICU_BUS_ACK);
  assign take_o = ack_o && cyc_i && stb_i;
endmodule : vicu_wb_slave

// >>> verification/vectored_interrupt_controller_test.sv
// register-level bench of the vectored interrupt unit
`include "vicu_cfg.svh"
module vectored_interrupt_controller_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, cyc, stb, we, fast, std, ev, ack;
  logic [3:0]  sel;
  logic [9:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [55:0] irq;
  logic [7:0]  fcnt, scnt;
  int          bad_count, n_checks;
  vicu_top DUT (.CLOCK_I(clk), .RESET_N_I(rst_n), .IRQ_REQ_I(irq), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .FAST_INTERRUPT_LINE_O(fast), .STD_INTERRUPT_LINE_O(std), .EVENT_IRQ_O(ev));
  vicu_core_model core (.clk_i(clk), .rst_n_i(rst_n), .fast_i(fast), .std_i(std),
    .fast_cnt_o(fcnt), .std_cnt_o(scnt));
  // free-running branch clock, 100 MHz
  always #5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one classic cycle; held until ack is sampled high, then one idle cycle
  // only the watchdog ends a wait for ack
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= s;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, 4'hf, r);
  endtask : wr
  // write through the chosen byte lanes only
  task automatic wrl(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    wb(1'b1, a, d, s, r);
  endtask : wrl
  task automatic rd(input logic [9:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, 4'hf, r);
    chk(nm, r, exp);
  endtask : rd
  // config word: priority, target, polarity, soft request
  function automatic logic [31:0] cfg(input logic [3:0] p, input logic t, input logic pl, input logic s);
    cfg = {7'h00, s, 7'h00, pl, 7'h00, t, 4'h0, p};
  endfunction : cfg
  function automatic logic [31:0] vexp(input logic [5:0] i, input logic [3:0] p);
    vexp = {15'h0000, 1'b1, 4'h0, p, 2'h0, i};
  endfunction : vexp
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  // hang guard, far beyond the hundred or so cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
  initial begin
    clk = 1'b0; rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    sel = 4'hf; adr = 10'h000; wdat = 32'h0; irq = 56'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("fast_idle", {31'h0, fast}, 32'h0);
    rd(`VICU_THR_FAST, 32'h0, "thr_fast_rst");
    rd(`VICU_VEC_FAST, 32'h3f, "vec_none");
    // low-active input 3 idles active; priority 0 keeps it off the lines
    wr(10'h00c, cfg(4'h0, 1'b0, 1'b1, 1'b0));
    rd(`VICU_RAW_LO, 32'h8, "raw_lo_pol");
    wr(10'h0a0, cfg(4'h0, 1'b0, 1'b0, 1'b1));
    rd(`VICU_RAW_HI, 32'h100, "raw_hi_soft");
    repeat (2) @(posedge clk);
    chk("fast_prio0", {31'h0, fast}, 32'h0);
    // equal priorities on inputs 5 and 7: the lower index wins
    irq[5] <= 1'b1;
    irq[7] <= 1'b1;
    wr(10'h014, cfg(4'h3, 1'b0, 1'b0, 1'b0));
    wr(10'h01c, cfg(4'h3, 1'b0, 1'b0, 1'b0));
    chk("fast_on", {31'h0, fast}, 32'h1);
    chk("std_off", {31'h0, std}, 32'h0);
    rd(`VICU_VEC_FAST, vexp(6'd5, 4'h3), "vec_tie");
    rd(`VICU_IRQ_STAT, 32'h1, "stat_rise");
    wr(`VICU_IRQ_MASK, 32'h1);
    chk("event_on", {31'h0, ev}, 32'h1);
    wr(`VICU_IRQ_STAT, 32'h1);
    chk("event_clr", {31'h0, ev}, 32'h0);
    // threshold equal to priority masks, one below lets it through again
    wr(`VICU_THR_FAST, 32'h3);
    repeat (2) @(posedge clk);
    chk("fast_thr_eq", {31'h0, fast}, 32'h0);
    wr(`VICU_THR_FAST, 32'h2);
    repeat (2) @(posedge clk);
    chk("fast_thr_lo", {31'h0, fast}, 32'h1);
    irq[50] <= 1'b1;
    wr(10'h0c8, cfg(4'hf, 1'b0, 1'b0, 1'b0));
    rd(10'h0c8, 32'hf, "cfg50_prio");
    rd(`VICU_VEC_FAST, vexp(6'd50, 4'hf), "vec_high");
    irq[9] <= 1'b1;
    wr(10'h024, cfg(4'h9, 1'b1, 1'b0, 1'b0));
    repeat (2) @(posedge clk);
    chk("std_on", {31'h0, std}, 32'h1);
    rd(`VICU_VEC_STD, vexp(6'd9, 4'h9), "vec_std");
    irq[9] <= 1'b0;
    repeat (2) @(posedge clk);
    chk("std_drop", {31'h0, std}, 32'h0);
    // fast bit set again by the rise after the threshold was lowered
    rd(`VICU_IRQ_STAT, 32'h3, "stat_std");
    // lane 0 only: priority moves, the target byte stays on the fast line
    wrl(10'h014, cfg(4'h4, 1'b1, 1'b0, 1'b0), 4'h1);
    rd(10'h014, 32'h4, "cfg5_lane0");
    wr(10'h200, 32'hffff_ffff);
    rd(10'h200, 32'h0, "unmapped");
    chk("core_fast", {24'h0, fcnt}, 32'h2);
    chk("core_std", {24'h0, scnt}, 32'h1);
    // warm reset in mid-run clears thresholds and configuration
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("fast_rst2", {31'h0, fast}, 32'h0);
    rd(`VICU_THR_FAST, 32'h0, "thr_fast_rst2");
    rd(10'h0c8, 32'h0, "cfg50_rst2");
    print_verdict();
  end
endmodule : vectored_interrupt_controller_test

// >>> verification/vicu_core_model.sv
// processor-side model: counts handler entries on the fast and standard lines
module vicu_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       fast_i,
  input  wire logic       std_i,
  output logic [7:0]      fast_cnt_o,
  output logic [7:0]      std_cnt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic fast_q;
  logic std_q;
  // a core enters a handler once per rising level; a held level is not a new entry
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fast_q     <= 1'b0;
      std_q      <= 1'b0;
      fast_cnt_o <= 8'h00;
      std_cnt_o  <= 8'h00;
    end else begin
      fast_q <= fast_i;
      std_q  <= std_i;
      if (fast_i && !fast_q) begin
        fast_cnt_o <= fast_cnt_o + 8'h01;
      end
      if (std_i && !std_q) begin
        std_cnt_o <= std_cnt_o + 8'h01;
      end
    end
  end
endmodule : vicu_core_model
